// [uac_pkg.sv]
package uac_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] UAC_DR_OFS    = 12'h000;
    localparam logic [11:0] UAC_RSR_OFS   = 12'h004;
    localparam logic [11:0] UAC_FR_OFS    = 12'h018;
    localparam logic [11:0] UAC_ILPR_OFS  = 12'h020;
    localparam logic [11:0] UAC_IBRD_OFS  = 12'h024;
    localparam logic [11:0] UAC_FBRD_OFS  = 12'h028;
    localparam logic [11:0] UAC_LCRH_OFS  = 12'h02C;
    localparam logic [11:0] UAC_CTL_OFS   = 12'h030;
    localparam logic [11:0] UAC_IFLS_OFS  = 12'h034;
    localparam logic [11:0] UAC_LVL_OFS   = 12'h048;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int          UAC_CTL_EN    = 0;
    localparam int          UAC_CTL_SIR   = 1;
    localparam int          UAC_CTL_SIRLP = 2;
    localparam int          UAC_CTL_TXE   = 8;
    localparam int          UAC_CTL_RXE   = 9;
    localparam int          UAC_FR_BUSY   = 3;
    localparam int          UAC_FR_RX_QUEUE_EMPTY_FLAG   = 4;
    localparam int          UAC_FR_TX_QUEUE_FULL_FLAG   = 5;
    localparam int          UAC_FR_RX_QUEUE_FULL_FLAG   = 6;
    localparam int          UAC_FR_TX_QUEUE_EMPTY_FLAG   = 7;
    localparam logic [31:0] UAC_CTL_RST   = 32'h0000_0300;
    localparam logic [5:0]  UAC_IFLS_RST  = 6'h12;

    // ****************************************
    // Timing counts in 16x ticks; pulse width in low-power ticks, step in 1/64 units
    // ****************************************
    localparam logic [3:0]  UAC_START_TICK = 4'h7;
    localparam logic [3:0]  UAC_LAST_TICK  = 4'hF;
    localparam logic [3:0]  UAC_SIR_TICKS  = 4'h3;
    localparam logic [1:0]  UAC_LP_PULSE   = 2'h3;
    localparam logic [22:0] UAC_FRAC_STEP  = 23'h00_0040;

    typedef struct packed {
        logic       sps;
        logic [1:0] wlen;
        logic       queue_enable_bit;
        logic       stp2;
        logic       eps;
        logic       pen;
        logic       brk;
    } uac_line_t;

    typedef struct packed {
        logic [15:0] ibrd;
        logic [5:0]  fbrd;
        uac_line_t   line;
    } uac_cfg_t;

    typedef struct packed {
        logic oe;
        logic be;
        logic pe;
        logic fe;
    } uac_err_t;

    typedef enum logic [4:0] {
        UAC_IDLE  = 5'b0_0001,
        UAC_START = 5'b0_0010,
        UAC_DATA  = 5'b0_0100,
        UAC_PAR   = 5'b0_1000,
        UAC_STOP  = 5'b1_0000
    } uac_ser_t;

endpackage

// [uac_core.sv]
`timescale 1ns/1ps
module uac_core
    import uac_pkg::*;
#(
    parameter int QDEPTH = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_rx_pin,
    output logic             serial_tx_pin
);
    localparam int AW = $clog2(QDEPTH);

    // Pointer arithmetic relies on natural wrap
    if (QDEPTH < 8 || (1 << AW) != QDEPTH) begin : g_depth_check
        $error("QDEPTH must be a power of two of at least 8");
    end

    typedef struct packed {
        uac_cfg_t                   cfg;
        logic [15:0]                ibrd;
        logic [5:0]                 fbrd;
        logic                       en, sir, sirlp, tx_enable_bit, rx_enable_bit;
        logic [5:0]                 ifls;
        logic [7:0]                 ilpr;
        uac_err_t                   rsr;
        logic [21:0]                bacc;
        logic                       tick;
        logic [7:0]                 lpcnt;
        logic                       lptick;
        logic [QDEPTH-1:0][7:0]     txq;
        logic [AW-1:0]              txw, txr;
        logic [AW:0]                txc;
        logic [QDEPTH-1:0][11:0]    rxq;
        logic [AW-1:0]              rxw, rxr;
        logic [AW:0]                rxc;
        uac_ser_t                   txs;
        logic [3:0]                 txsub;
        logic [2:0]                 txbit;
        logic [7:0]                 txsh;
        logic                       txpar;
        logic [1:0]                 lpw;
        logic                       txo;
        uac_ser_t                   rxs;
        logic [3:0]                 rxsub;
        logic [2:0]                 rxbit;
        logic [7:0]                 rxsh;
        logic                       rxpe;
        logic                       ovr;
        logic                       rxhi;
        logic                       rs1, rs2;
        logic [3:0]                 stretch;
        logic [31:0]                prd;
        logic                       popok;
    } uac_st_t;

    uac_st_t s_q, s_d;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] uac_mask(input logic [7:0] d, input logic [1:0] wl);
        uac_mask = d & (8'hFF >> (2'd3 - wl));
    endfunction

    // Parity over the active bits; stick parity ignores the data
    function automatic logic uac_par(input logic [7:0] d, input uac_line_t ln);
        if (ln.sps) begin
            uac_par = ~ln.eps;
        end else begin
            uac_par = (^uac_mask(d, ln.wlen)) ^ ~ln.eps;
        end
    endfunction

    // Trigger level in entries: 1/8, 1/4, 1/2, 3/4, 7/8
    function automatic logic [AW:0] uac_lvl(input logic [2:0] sel);
        case (sel)
            3'd0:    uac_lvl = (AW+1)'(QDEPTH / 8);
            3'd1:    uac_lvl = (AW+1)'(QDEPTH / 4);
            3'd3:    uac_lvl = (AW+1)'(QDEPTH * 3 / 4);
            3'd4:    uac_lvl = (AW+1)'(QDEPTH * 7 / 8);
            default: uac_lvl = (AW+1)'(QDEPTH / 2);
        endcase
    endfunction

    logic [AW:0]  depth;
    logic         txfull, rxfull, txempty, rxempty, busy;
    logic         acc, setup, rxl, txbitv, push_tx, pop_tx, push_rx, pop_rx;
    logic [2:0]   nbits;
    logic [22:0]  bsum;
    logic [21:0]  div;
    logic [7:0]   rxdat;
    logic [11:0]  rdmux;
    logic         hit;

    always_comb begin
        s_d     = s_q;
        // One entry deep until queues are enabled
        depth   = s_q.cfg.line.queue_enable_bit ? (AW+1)'(QDEPTH) : (AW+1)'(1);
        txfull  = s_q.txc >= depth;
        rxfull  = s_q.rxc >= depth;
        txempty = s_q.txc == '0;
        rxempty = s_q.rxc == '0;
        busy    = !txempty || s_q.txs != UAC_IDLE;
        acc     = psel && penable;
        setup   = psel && !penable;
        nbits   = {1'b1, s_q.cfg.line.wlen};
        push_tx = 1'b0;
        pop_tx  = 1'b0;
        push_rx = 1'b0;
        pop_rx  = 1'b0;
        rxdat   = 8'(s_q.rxsh >> (2'd3 - s_q.cfg.line.wlen));

        // ****************************************
        // 16x tick, fractional accumulator
        // ****************************************
        // Adds 64 per clock against a divisor in 1/64 units; averages the fraction
        div  = {s_q.cfg.ibrd, s_q.cfg.fbrd};
        bsum = {1'b0, s_q.bacc} + UAC_FRAC_STEP;
        s_d.tick = 1'b0;
        if (s_q.cfg.ibrd == '0) begin
            s_d.bacc = '0;
        end else if (bsum >= {1'b0, div}) begin
            s_d.tick = 1'b1;
            s_d.bacc = 22'(bsum - {1'b0, div});
        end else begin
            s_d.bacc = bsum[21:0];
        end

        // Low-power infrared tick; a zero divisor stops it
        s_d.lptick = 1'b0;
        if (s_q.ilpr == '0) begin
            s_d.lpcnt = '0;
        end else if (s_q.lpcnt == '0) begin
            s_d.lpcnt  = s_q.ilpr - 8'h01;
            s_d.lptick = 1'b1;
        end else begin
            s_d.lpcnt = s_q.lpcnt - 8'h01;
        end

        // ****************************************
        // Register bus
        // ****************************************
        hit = paddr inside {UAC_DR_OFS, UAC_RSR_OFS, UAC_FR_OFS, UAC_ILPR_OFS,
                            UAC_IBRD_OFS, UAC_FBRD_OFS, UAC_LCRH_OFS, UAC_CTL_OFS,
                            UAC_IFLS_OFS, UAC_LVL_OFS};
        rdmux = s_q.rxq[s_q.rxr];
        // Read data captured in setup so it comes from a flip-flop
        if (setup) begin
            s_d.popok = 1'b0;
            s_d.prd   = '0;
            case (paddr)
                UAC_DR_OFS: begin
                    s_d.prd   = {20'h0_0000, rdmux};
                    s_d.popok = !rxempty;
                end
                UAC_RSR_OFS:  s_d.prd = {28'h000_0000, s_q.rsr};
                UAC_FR_OFS: begin
                    s_d.prd[UAC_FR_BUSY] = busy;
                    s_d.prd[UAC_FR_RX_QUEUE_EMPTY_FLAG] = rxempty;
                    s_d.prd[UAC_FR_TX_QUEUE_FULL_FLAG] = txfull;
                    s_d.prd[UAC_FR_RX_QUEUE_FULL_FLAG] = rxfull;
                    s_d.prd[UAC_FR_TX_QUEUE_EMPTY_FLAG] = txempty;
                end
                UAC_ILPR_OFS: s_d.prd = {24'h00_0000, s_q.ilpr};
                UAC_IBRD_OFS: s_d.prd = {16'h0000, s_q.ibrd};
                UAC_FBRD_OFS: s_d.prd = {26'h000_0000, s_q.fbrd};
                UAC_LCRH_OFS: s_d.prd = {24'h00_0000, s_q.cfg.line};
                UAC_CTL_OFS: begin
                    s_d.prd[UAC_CTL_EN]    = s_q.en;
                    s_d.prd[UAC_CTL_SIR]   = s_q.sir;
                    s_d.prd[UAC_CTL_SIRLP] = s_q.sirlp;
                    s_d.prd[UAC_CTL_TXE]   = s_q.tx_enable_bit;
                    s_d.prd[UAC_CTL_RXE]   = s_q.rx_enable_bit;
                end
                UAC_IFLS_OFS: s_d.prd = {26'h000_0000, s_q.ifls};
                UAC_LVL_OFS: begin
                    s_d.prd[0] = s_q.rxc >= uac_lvl(s_q.ifls[5:3]);
                    s_d.prd[1] = s_q.txc <= uac_lvl(s_q.ifls[2:0]);
                end
                default: s_d.prd = '0;
            endcase
        end
        // Writes and pops take effect only in the access phase
        if (acc && pwrite) begin
            case (paddr)
                UAC_DR_OFS:   push_tx = !txfull;
                UAC_RSR_OFS:  s_d.rsr = '0;
                UAC_ILPR_OFS: s_d.ilpr = pwdata[7:0];
                UAC_IBRD_OFS: s_d.ibrd = pwdata[15:0];
                UAC_FBRD_OFS: s_d.fbrd = pwdata[5:0];
                // Divisors only reach the generator with a line write
                UAC_LCRH_OFS: s_d.cfg = {s_q.ibrd, s_q.fbrd, pwdata[7:0]};
                UAC_CTL_OFS: begin
                    s_d.en    = pwdata[UAC_CTL_EN];
                    s_d.sir   = pwdata[UAC_CTL_SIR];
                    s_d.sirlp = pwdata[UAC_CTL_SIRLP];
                    s_d.tx_enable_bit   = pwdata[UAC_CTL_TXE];
                    s_d.rx_enable_bit   = pwdata[UAC_CTL_RXE];
                end
                UAC_IFLS_OFS: s_d.ifls = pwdata[5:0];
                default: ;
            endcase
        end else if (acc && paddr == UAC_DR_OFS && s_q.popok) begin
            pop_rx = 1'b1;
            s_d.rsr.fe = rdmux[8];
            s_d.rsr.pe = rdmux[9];
            s_d.rsr.be = rdmux[10];
        end

        // ****************************************
        // Transmitter
        // ****************************************
        if (s_q.tick && s_q.txs != UAC_IDLE) begin
            s_d.txsub = s_q.txsub + 4'h1;
        end
        case (s_q.txs)
            UAC_IDLE: begin
                // Start on a tick so the start bit spans whole ticks like the rest
                if (s_q.tick && s_q.en && s_q.tx_enable_bit && !txempty) begin
                    pop_tx     = 1'b1;
                    s_d.txsh   = uac_mask(s_q.txq[s_q.txr], s_q.cfg.line.wlen);
                    s_d.txpar  = uac_par(s_q.txq[s_q.txr], s_q.cfg.line);
                    s_d.txsub  = '0;
                    s_d.txs    = UAC_START;
                end
            end
            UAC_START: begin
                if (s_q.tick && s_q.txsub == UAC_LAST_TICK) begin
                    s_d.txs   = UAC_DATA;
                    s_d.txbit = '0;
                end
            end
            UAC_DATA: begin
                if (s_q.tick && s_q.txsub == UAC_LAST_TICK) begin
                    s_d.txsh  = s_q.txsh >> 1;
                    s_d.txbit = s_q.txbit + 3'h1;
                    if (s_q.txbit == nbits) begin
                        s_d.txbit = '0;
                        s_d.txs   = s_q.cfg.line.pen ? UAC_PAR : UAC_STOP;
                    end
                end
            end
            UAC_PAR: begin
                if (s_q.tick && s_q.txsub == UAC_LAST_TICK) begin
                    s_d.txs = UAC_STOP;
                end
            end
            UAC_STOP: begin
                if (s_q.tick && s_q.txsub == UAC_LAST_TICK) begin
                    if (s_q.cfg.line.stp2 && s_q.txbit == '0) begin
                        s_d.txbit = 3'h1;
                    end else begin
                        s_d.txs = UAC_IDLE;
                    end
                end
            end
            default: s_d.txs = UAC_IDLE;
        endcase

        case (s_q.txs)
            UAC_START: txbitv = 1'b0;
            UAC_DATA:  txbitv = s_q.txsh[0];
            UAC_PAR:   txbitv = s_q.txpar;
            default:   txbitv = 1'b1;
        endcase
        if (s_q.cfg.line.brk) begin
            txbitv = 1'b0;
        end

        // ****************************************
        // Infrared encoder
        // ****************************************
        // Low-power width counts its own tick, so jitter is one low-power period
        if (s_q.tick && s_q.txsub == '0 && !txbitv && s_q.txs != UAC_IDLE) begin
            s_d.lpw = UAC_LP_PULSE;
        end else if (s_q.lptick && s_q.lpw != '0) begin
            s_d.lpw = s_q.lpw - 2'h1;
        end
        if (!s_q.sir) begin
            s_d.txo = txbitv;
        end else if (s_q.sirlp) begin
            s_d.txo = s_q.lpw != '0;
        end else begin
            s_d.txo = !txbitv && s_q.txsub < UAC_SIR_TICKS;
        end

        // ****************************************
        // Receiver
        // ****************************************
        s_d.rs1 = serial_rx_pin;
        s_d.rs2 = s_q.rs1;
        // Light pulse pulls the pin low; stretched to cover the mid-bit sample
        if (!s_q.rs2) begin
            s_d.stretch = UAC_LAST_TICK;
        end else if (s_q.tick && s_q.stretch != '0) begin
            s_d.stretch = s_q.stretch - 4'h1;
        end
        rxl = s_q.sir ? (s_q.rs2 && s_q.stretch == '0) : s_q.rs2;

        if (s_q.tick && s_q.rxs != UAC_IDLE) begin
            s_d.rxsub = s_q.rxsub + 4'h1;
        end
        case (s_q.rxs)
            UAC_IDLE: begin
                s_d.rxsub = '0;
                if (rxl) begin
                    s_d.rxhi = 1'b1;
                end else if (s_q.rxhi && s_q.en && s_q.rx_enable_bit) begin
                    s_d.rxhi = 1'b0;
                    s_d.rxs  = UAC_START;
                end
            end
            UAC_START: begin
                if (s_q.tick && s_q.rxsub == UAC_START_TICK) begin
                    s_d.rxsub = '0;
                    s_d.rxbit = '0;
                    s_d.rxpe  = 1'b0;
                    s_d.rxs   = rxl ? UAC_IDLE : UAC_DATA;
                end
            end
            UAC_DATA: begin
                if (s_q.tick && s_q.rxsub == UAC_LAST_TICK) begin
                    s_d.rxsh  = {rxl, s_q.rxsh[7:1]};
                    s_d.rxbit = s_q.rxbit + 3'h1;
                    if (s_q.rxbit == nbits) begin
                        s_d.rxs = s_q.cfg.line.pen ? UAC_PAR : UAC_STOP;
                    end
                end
            end
            UAC_PAR: begin
                if (s_q.tick && s_q.rxsub == UAC_LAST_TICK) begin
                    s_d.rxpe = rxl != uac_par(rxdat, s_q.cfg.line);
                    s_d.rxs  = UAC_STOP;
                end
            end
            UAC_STOP: begin
                if (s_q.tick && s_q.rxsub == UAC_LAST_TICK) begin
                    s_d.rxs = UAC_IDLE;
                    // Full queue drops the character and marks the next one
                    if (rxfull) begin
                        s_d.ovr    = 1'b1;
                        s_d.rsr.oe = 1'b1;
                    end else begin
                        push_rx = 1'b1;
                    end
                end
            end
            default: s_d.rxs = UAC_IDLE;
        endcase

        // ****************************************
        // Queues
        // ****************************************
        if (push_tx) begin
            s_d.txq[s_q.txw] = pwdata[7:0];
            s_d.txw = s_q.txw + AW'(1);
        end
        if (pop_tx) begin
            s_d.txr = s_q.txr + AW'(1);
        end
        s_d.txc = s_q.txc + (AW+1)'(push_tx) - (AW+1)'(pop_tx);
        if (push_rx) begin
            // All-low frame: zero data, zero parity, low stop is a break
            s_d.rxq[s_q.rxw] = {s_q.ovr,
                                !rxl && rxdat == '0 && (!s_q.cfg.line.pen || s_q.rxpe
                                    == uac_par(8'h00, s_q.cfg.line)),
                                s_q.rxpe, !rxl, rxdat};
            s_d.rxw = s_q.rxw + AW'(1);
            s_d.ovr = 1'b0;
        end
        if (pop_rx) begin
            s_d.rxr = s_q.rxr + AW'(1);
        end
        s_d.rxc = s_q.rxc + (AW+1)'(push_rx) - (AW+1)'(pop_rx);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q       <= '0;
            s_q.tx_enable_bit   <= UAC_CTL_RST[UAC_CTL_TXE];
            s_q.rx_enable_bit   <= UAC_CTL_RST[UAC_CTL_RXE];
            s_q.ifls  <= UAC_IFLS_RST;
            s_q.txs   <= UAC_IDLE;
            s_q.rxs   <= UAC_IDLE;
            s_q.txo   <= 1'b1;
            s_q.rs1   <= 1'b1;
            s_q.rs2   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Zero-wait slave; unmapped offsets answer with an error
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && !hit;
    assign prdata        = s_q.prd;
    assign serial_tx_pin = s_q.txo;

endmodule

// [uac_monitor.sv]
`timescale 1ns/1ps
module uac_monitor
    import uac_pkg::*;
#(
    parameter int BIT_CLKS = 32
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_rx_pin,
    input wire logic        serial_tx_pin
);
    // ****
    // Helpers
    // ****
    logic        mapped;
    logic        rd_acc;
    logic [15:0] low_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded offsets, so a gap in the map shows up as a slave error
    assign mapped = paddr inside {UAC_DR_OFS, UAC_RSR_OFS, UAC_FR_OFS, UAC_ILPR_OFS,
        UAC_IBRD_OFS, UAC_FBRD_OFS, UAC_LCRH_OFS, UAC_CTL_OFS, UAC_IFLS_OFS, UAC_LVL_OFS};
    assign rd_acc = psel && penable && !pwrite;
    // Length of each low stretch on the line; frames come in whole bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_q <= 16'h0000;
        else if (serial_tx_pin) low_q <= 16'h0000;
        else low_q <= low_q + 16'h0001;
    end
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_err; psel && penable && !mapped |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("hole not refused");
    property p_ok; psel && penable && mapped |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_hole; rd_acc && !mapped |-> prdata == 32'h0000_0000; endproperty
    a_hole: assert property (p_hole) else $error("hole read not zero");
    property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_fr; rd_acc && paddr == UAC_FR_OFS |-> prdata[31:8] == 24'h00_0000; endproperty
    a_fr: assert property (p_fr) else $error("flag spare bits set");
    property p_dr; rd_acc && paddr == UAC_DR_OFS |-> prdata[31:12] == 20'h0_0000; endproperty
    a_dr: assert property (p_dr) else $error("data word too wide");
    property p_idle; $rose(presetn) |-> serial_tx_pin ##1 serial_tx_pin; endproperty
    a_idle: assert property (p_idle) else $error("line not idle high");
    property p_bit; $rose(serial_tx_pin) |-> (low_q % BIT_CLKS) == 0; endproperty
    a_bit: assert property (p_bit) else $error("partial bit low");
endmodule

// [uac_partner.sv]
`timescale 1ns/1ps
module uac_partner #(
    parameter int BIT_CLKS = 32
) (
    input  wire logic pclk,
    input  wire logic tx_line,
    output logic      rx_line
);
    logic [7:0] got[$];
    logic [7:0] sh;
    // Line rests high so no false start is seen
    initial rx_line = 1'b1;
    // Start, data low bit first, then a chosen stop level
    task automatic send(input logic [7:0] b, input logic stop);
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            rx_line <= (i == 0) ? 1'b0 : (i == 9) ? stop : b[i - 1];
            repeat (BIT_CLKS - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rx_line <= 1'b1;
        repeat (BIT_CLKS) @(posedge pclk);
    endtask
    // Infrared: each zero is a short low pulse, a one leaves the line high
    task automatic send_ir(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            rx_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
            repeat (5) @(posedge pclk);
            rx_line <= 1'b1;
            repeat (BIT_CLKS - 6) @(posedge pclk);
        end
        repeat (BIT_CLKS) @(posedge pclk);
    endtask
    // Mid-bit sampler; a frame without a high stop is dropped
    always begin
        @(negedge tx_line);
        repeat (BIT_CLKS / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge pclk);
            sh[i] = tx_line;
        end
        repeat (BIT_CLKS) @(posedge pclk);
        if (tx_line === 1'b1) got.push_back(sh);
    end
endmodule

// [uac_core_test.sv]
`timescale 1ns/1ps
module uac_core_test;
    import uac_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxl, txl, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          bad_count, cmp_count;
    uac_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_rx_pin(rxl), .serial_tx_pin(txl));
    uac_partner #(.BIT_CLKS(32)) mdl (.pclk(pclk), .tx_line(txl), .rx_line(rxl));
    // ****
    // Bus and compare helpers
    // ****
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Slave may stretch; the watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    task automatic complete_run;
        if (bad_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset_vals;
        rdc("ctl", UAC_CTL_OFS, 32'h0000_0300);
        rdc("flags", UAC_FR_OFS, 32'h0000_0090);
        rdc("levels", UAC_IFLS_OFS, 32'h0000_0012);
        rdc("hole", 12'h008, 32'h0000_0000);
        chk("hole err", 32'h1, {31'h0, err});
    endtask
    task automatic t_tx;
        apb(1'b1, UAC_IBRD_OFS, 32'h0000_0002);
        apb(1'b1, UAC_FBRD_OFS, 32'h0000_0000);
        apb(1'b1, UAC_LCRH_OFS, 32'h0000_0070);
        apb(1'b1, UAC_CTL_OFS, 32'h0000_0301);
        apb(1'b1, UAC_DR_OFS, 32'h0000_00A5);
        apb(1'b1, UAC_DR_OFS, 32'h0000_003C);
        // First character already shifting, second queued, receive side still empty
        rdc("busy", UAC_FR_OFS, 32'h0000_0018);
        for (int n = 0; n < 400 && rd[UAC_FR_BUSY] !== 1'b0; n++) begin
            apb(1'b0, UAC_FR_OFS, 32'h0);
        end
        chk("idle flags", 32'h0000_0090, rd);
        chk("sent count", 32'd2, mdl.got.size());
        chk("first", 32'h0000_00A5, {24'h0, mdl.got[0]});
        chk("second", 32'h0000_003C, {24'h0, mdl.got[1]});
    endtask
    task automatic t_rx;
        mdl.send(8'h5A, 1'b1);
        rdc("rx good", UAC_DR_OFS, 32'h0000_005A);
        mdl.send(8'hC3, 1'b0);
        rdc("rx frame", UAC_DR_OFS, 32'h0000_01C3);
        mdl.send(8'h00, 1'b0);
        rdc("rx break", UAC_DR_OFS, 32'h0000_0500);
        rdc("status", UAC_RSR_OFS, 32'h0000_0005);
        apb(1'b1, UAC_RSR_OFS, 32'h0000_0000);
        rdc("status clr", UAC_RSR_OFS, 32'h0000_0000);
        rdc("rx empty", UAC_FR_OFS, 32'h0000_0090);
    endtask
    // Infrared receive; nothing was sent in infrared, so no turnaround wait is owed
    task automatic t_ir;
        apb(1'b1, UAC_CTL_OFS, 32'h0000_0300);
        apb(1'b1, UAC_CTL_OFS, 32'h0000_0303);
        mdl.send_ir(8'h96);
        rdc("ir rx", UAC_DR_OFS, 32'h0000_0096);
        chk("ir tx idle", 32'h0, {31'h0, txl});
    endtask
    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_tx();
        t_rx();
        t_ir();
        complete_run();
    end
    // Watchdog, several times the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        complete_run();
    end
endmodule
bind uac_core uac_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin));
